// ---- verilog/fpcs_pkg.sv ----
// Purpose: shared constants and types of the fast clock synthesizer
// Assumes: hclk at 40 MHz; one hclk cycle models one eighth of an
//          oscillator period
// Notes:   byte offsets of the AHB-Lite register map
`default_nettype none
package fpcs_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 40;
  localparam int SETTLE_US = 10;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int STEPS_PER_VCO = 8;

  // ****************************************
  // ranges
  // ****************************************
  localparam int MAX_DIV = 32;
  localparam int SERDES_MAX_MULT = 30;
  localparam int SERDES_DIV = 1;
  localparam int VCO_MIN_MHZ = 300;
  localparam int VCO_MAX_MHZ = 1000;
  localparam int NUM_OUT = 3;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MULT_OFS = 8'h04;
  localparam logic [7:0] DIV_R0_OFS = 8'h08;
  localparam logic [7:0] DIV_R1_OFS = 8'h0C;
  localparam logic [7:0] GOD_OFS = 8'h10;
  localparam logic [7:0] SHIFT_OFS = 8'h14;
  localparam logic [7:0] REF_MHZ_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h24;
  localparam logic [7:0] UNMAPPED = 8'hFF;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CTRL_SERDES_BIT = 0;
  localparam int CTRL_CSHIFT_BIT = 1;
  localparam int CTRL_EXT_LSB = 2;
  localparam int SHIFT_R1_LSB = 8;
  localparam int SHIFT_G_LSB = 16;
  localparam int IRQ_GAIN = 0;
  localparam int IRQ_LOST = 1;
  localparam int IRQ_STOP = 2;
  localparam logic [5:0] MULT_RST = 6'h08;
  localparam logic [5:0] DIV_RST = 6'h01;
  localparam logic [9:0] REF_MHZ_RST = 10'h064;

  // lock sequencer states
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_ACQ = 3'b010,
    ST_LOCK = 3'b100
  } fpcs_state_t;

endpackage
`default_nettype wire

// ---- verilog/fpcs_div_if.sv ----
// Purpose: link between the sequencer and one post-scale divider
// Assumes: driven in the hclk domain
// Notes:   ctrl side sets up, div side returns the divided clock
`timescale 1ns/1ps
`default_nettype none
interface fpcs_div_if;
  logic [5:0] div;
  logic [7:0] shift;
  logic run;
  logic sync;
  logic clk_out;
  modport ctrl (output div, output shift, output run, output sync, input clk_out);
  modport div_end (input div, input shift, input run, input sync, output clk_out);
endinterface
`default_nettype wire

// ---- verilog/fpcs_post_div.sv ----
// Purpose: one post-scale divider with eighth-period phase offset
// Assumes: one hclk cycle is one eighth of an oscillator period
// Notes:   output is a registered square wave of 8*div cycles for div up to 32 (div 0 acts as 1); the 8-bit count wraps at 256 above 32
`timescale 1ns/1ps
`default_nettype none
module fpcs_post_div
  import fpcs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  fpcs_div_if.div_end port
);

  typedef struct packed {
    logic [7:0] cnt;
    logic out;
  } fpcs_pd_state_t;

  fpcs_pd_state_t s;
  fpcs_pd_state_t next_s;
  logic [5:0] eff;
  logic [8:0] period;
  logic [8:0] half;
  logic [8:0] start;

  // ****************************************
  // divider counter
  // ****************************************
  always_comb begin
    eff = (port.div == 6'h00) ? 6'h01 : port.div;
    period = {eff, 3'b000};
    half = {1'b0, eff, 2'b00};
    // offset in eighth steps; a shift of one output period or more gives no offset
    if ((port.shift == 8'h00) || ({1'b0, port.shift} >= period)) begin
      start = 9'h000;
    end else begin
      start = period - {1'b0, port.shift};
    end
    next_s = s;
    if (!port.run) begin
      next_s = '0;
    end else begin
      if (port.sync) begin
        next_s.cnt = start[7:0];
      end else if ({1'b0, s.cnt} >= period - 9'h001) begin
        next_s.cnt = 8'h00;
      end else begin
        next_s.cnt = s.cnt + 8'h01;
      end
      next_s.out = ({1'b0, next_s.cnt} < half);
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign port.clk_out = s.out;

endmodule // fpcs_post_div
`default_nettype wire

// ---- verilog/fpcs_top.sv ----
// Purpose: counter and control logic of a fast clock synthesizer
// Assumes: ref_clk_in, pll_enable and pll_areset synchronous to hclk
// Notes:   zero-wait AHB-Lite slave, response always OKAY
`timescale 1ns/1ps
`default_nettype none

module fpcs_top
  import fpcs_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ref_clk_in,
  input wire logic pll_enable,
  input wire logic pll_areset,
  output logic regional_clk_0,
  output logic regional_clk_1,
  output logic global_clk,
  output logic ext_clk_pin,
  output logic locked,
  output logic irq
);

  // ****************************************
  // parameter check
  // ****************************************
  if (SETTLE_CYCLES < 2 || SETTLE_CYCLES > 4095) begin : g_bad
    $error("SETTLE_CYCLES out of range");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    fpcs_state_t st;
    logic serdes;
    logic cshift;
    logic [1:0] ext_sel;
    logic [5:0] mult;
    logic [5:0] div_r0;
    logic [5:0] div_r1;
    logic [5:0] global_output_divider;
    logic [7:0] sh0;
    logic [7:0] sh1;
    logic [7:0] sh2;
    logic [9:0] ref_mhz;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [8:0] fb_cnt;
    logic [11:0] settle;
    logic [9:0] watch;
    logic ref_q;
    logic sync;
    logic ap_valid;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic ext_clk;
  } fpcs_top_state_t;

  fpcs_top_state_t s;
  fpcs_top_state_t next_s;
  logic run;
  logic ref_rise;
  logic aligned;
  logic cfg_ok;
  logic watch_to;
  logic [8:0] fb_per;
  logic [9:0] watch_lim;
  logic [15:0] vco_mhz;
  logic [2:0] ev;
  logic [2:0] clk_vec;
  logic [2:0][5:0] div_a;
  logic [2:0][7:0] sh_a;

  // ****************************************
  // configuration check
  // ****************************************
  function automatic logic in_range(input logic [5:0] v);
    in_range = (v != 6'h00) && (v <= 6'(MAX_DIV));
  endfunction

  // oscillator band and serializer limits
  always_comb begin
    vco_mhz = 16'(s.mult) * 16'(s.ref_mhz);
    cfg_ok = in_range(s.mult)
      && in_range(s.div_r0) && in_range(s.div_r1)
      && in_range(s.global_output_divider)
      && (vco_mhz >= 16'(VCO_MIN_MHZ))
      && (vco_mhz <= 16'(VCO_MAX_MHZ))
      && (!s.serdes || ((s.mult <= 6'(SERDES_MAX_MULT))
      && (s.div_r0 == 6'(SERDES_DIV))));
  end

  // ****************************************
  // register read mux
  // ****************************************
  function automatic logic [31:0] rd_mux(
    input fpcs_top_state_t x,
    input logic [7:0] a,
    input logic ok
  );
    rd_mux = 32'h0000_0000;
    if (a == CTRL_OFS) begin
      rd_mux[CTRL_SERDES_BIT] = x.serdes;
      rd_mux[CTRL_CSHIFT_BIT] = x.cshift;
      rd_mux[CTRL_EXT_LSB +: 2] = x.ext_sel;
    end else if (a == MULT_OFS) begin
      rd_mux[5:0] = x.mult;
    end else if (a == DIV_R0_OFS) begin
      rd_mux[5:0] = x.div_r0;
    end else if (a == DIV_R1_OFS) begin
      rd_mux[5:0] = x.div_r1;
    end else if (a == GOD_OFS) begin
      rd_mux[5:0] = x.global_output_divider;
    end else if (a == SHIFT_OFS) begin
      rd_mux[7:0] = x.sh0;
      rd_mux[SHIFT_R1_LSB +: 8] = x.sh1;
      rd_mux[SHIFT_G_LSB +: 8] = x.sh2;
    end else if (a == REF_MHZ_OFS) begin
      rd_mux[9:0] = x.ref_mhz;
    end else if (a == STATUS_OFS) begin
      rd_mux[0] = (x.st == ST_LOCK);
      rd_mux[1] = ok;
      rd_mux[2] = (x.st == ST_ACQ);
    end else if (a == IRQ_STAT_OFS) begin
      rd_mux[2:0] = x.irq_stat;
    end else if (a == IRQ_MASK_OFS) begin
      rd_mux[2:0] = x.irq_mask;
    end
  endfunction

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_s = s;
    ev = 3'b000;
    run = pll_enable && !pll_areset;
    ref_rise = ref_clk_in && !s.ref_q;
    fb_per = {s.mult, 3'b000};
    watch_lim = {fb_per, 1'b0};
    aligned = (s.fb_cnt == fb_per - 9'h001);
    watch_to = (s.watch >= watch_lim);
    next_s.ref_q = ref_clk_in;
    next_s.sync = 1'b0;

    // bus data phase: register writes
    if (s.ap_valid && s.ap_wr) begin
      if (s.ap_addr == CTRL_OFS) begin
        next_s.serdes = hwdata[CTRL_SERDES_BIT];
        next_s.cshift = hwdata[CTRL_CSHIFT_BIT];
        next_s.ext_sel = hwdata[CTRL_EXT_LSB +: 2];
      end else if (s.ap_addr == MULT_OFS) begin
        next_s.mult = hwdata[5:0];
      end else if (s.ap_addr == DIV_R0_OFS) begin
        next_s.div_r0 = hwdata[5:0];
      end else if (s.ap_addr == DIV_R1_OFS) begin
        next_s.div_r1 = hwdata[5:0];
      end else if (s.ap_addr == GOD_OFS) begin
        next_s.global_output_divider = hwdata[5:0];
      end else if (s.ap_addr == SHIFT_OFS) begin
        next_s.sh0 = hwdata[7:0];
        next_s.sh1 = hwdata[SHIFT_R1_LSB +: 8];
        next_s.sh2 = hwdata[SHIFT_G_LSB +: 8];
      end else if (s.ap_addr == REF_MHZ_OFS) begin
        next_s.ref_mhz = hwdata[9:0];
      end else if (s.ap_addr == IRQ_STAT_OFS) begin
        next_s.irq_stat = s.irq_stat & ~hwdata[2:0];
      end else if (s.ap_addr == IRQ_MASK_OFS) begin
        next_s.irq_mask = hwdata[2:0];
      end
    end

    // feedback counter and lock sequencer
    if (!run) begin
      // disable or reset: counters clear, lock drops at once
      next_s.st = ST_OFF;
      next_s.fb_cnt = 9'h000;
      next_s.settle = 12'h000;
      next_s.watch = 10'h000;
      if (s.st == ST_LOCK) begin
        ev[IRQ_LOST] = 1'b1;
      end
    end else begin
      // feedback divides the oscillator by the multiply value
      if (s.fb_cnt >= fb_per - 9'h001) begin
        next_s.fb_cnt = 9'h000;
      end else begin
        next_s.fb_cnt = s.fb_cnt + 9'h001;
      end
      // reference watchdog
      if (ref_rise) begin
        next_s.watch = 10'h000;
      end else if (!watch_to) begin
        next_s.watch = s.watch + 10'h001;
      end
      // misaligned edge: pull feedback and outputs onto it
      if (ref_rise && !aligned) begin
        next_s.fb_cnt = 9'h000;
        next_s.sync = 1'b1;
      end
      case (s.st)
        ST_OFF: begin
          // leaving reset or disable: resynchronize
          next_s.st = ST_ACQ;
          next_s.settle = 12'h000;
          next_s.sync = 1'b1;
        end
        ST_ACQ: begin
          if ((ref_rise && !aligned) || !cfg_ok || watch_to) begin
            next_s.settle = 12'h000;
          end else if (s.settle == 12'(SETTLE_CYCLES - 1)) begin
            next_s.st = ST_LOCK;
            ev[IRQ_GAIN] = 1'b1;
          end else begin
            next_s.settle = s.settle + 12'h001;
          end
        end
        ST_LOCK: begin
          if ((ref_rise && !aligned) || !cfg_ok || watch_to) begin
            next_s.st = ST_ACQ;
            next_s.settle = 12'h000;
            ev[IRQ_LOST] = 1'b1;
            ev[IRQ_STOP] = watch_to;
          end
        end
        default: begin
          next_s.st = ST_OFF;
        end
      endcase
    end
    // sticky events, set wins over clear
    next_s.irq_stat = next_s.irq_stat | ev;
    // external pin routing from any output
    case (s.ext_sel)
      2'd0: next_s.ext_clk = clk_vec[0];
      2'd1: next_s.ext_clk = clk_vec[1];
      2'd2: next_s.ext_clk = clk_vec[2];
      default: next_s.ext_clk = 1'b0;
    endcase
    // bus address phase
    next_s.ap_valid = hsel && hready && htrans[1];
    next_s.ap_wr = hwrite;
    next_s.ap_addr = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : UNMAPPED;
    if (hsel && hready && htrans[1] && !hwrite) begin
      next_s.rdata = rd_mux(next_s, next_s.ap_addr, cfg_ok);
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{st: ST_OFF, mult: MULT_RST, div_r0: DIV_RST,
             div_r1: DIV_RST, global_output_divider: DIV_RST,
             ref_mhz: REF_MHZ_RST, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // post-scale dividers
  // ****************************************
  assign div_a[0] = s.div_r0;
  assign div_a[1] = s.div_r1;
  assign div_a[2] = s.global_output_divider;
  // common shift copies the first output's setting
  assign sh_a[0] = s.sh0;
  assign sh_a[1] = s.cshift ? s.sh0 : s.sh1;
  assign sh_a[2] = s.cshift ? s.sh0 : s.sh2;

  generate
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
      fpcs_div_if dif ();
      assign dif.div = div_a[i];
      assign dif.shift = sh_a[i];
      assign dif.run = run;
      assign dif.sync = s.sync;
      assign clk_vec[i] = dif.clk_out;
      fpcs_post_div u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .port(dif.div_end)
      );
    end
  endgenerate

  // ****************************************
  // outputs
  // ****************************************
  assign regional_clk_0 = clk_vec[0];
  assign regional_clk_1 = clk_vec[1];
  assign global_clk = clk_vec[2];
  assign ext_clk_pin = s.ext_clk;
  assign locked = (s.st == ST_LOCK);
  assign irq = |(s.irq_stat & s.irq_mask);
  assign hrdata = s.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence seq_off_req;
    !pll_enable || pll_areset;
  endsequence
  sequence seq_settled;
    s.st == ST_ACQ && s.settle == 12'(SETTLE_CYCLES - 1);
  endsequence

  a_off_outputs_low: assert property (
    seq_off_req |=> !locked && !global_clk && !regional_clk_0 && !regional_clk_1)
    else $error("outputs or lock active while off");
  a_reset_clears_cnt: assert property (
    pll_areset |=> s.fb_cnt == 9'h000 && s.settle == 12'h000 && s.st == ST_OFF)
    else $error("reset did not clear counters");
  // lock follows the settings one cycle late, so check those it saw
  a_lock_needs_cfg: assert property (
    locked |-> $past(vco_mhz >= 16'(VCO_MIN_MHZ) && vco_mhz <= 16'(VCO_MAX_MHZ)))
    else $error("locked outside oscillator band");
  a_fb_in_range: assert property (
    locked && $past(s.mult) == s.mult |-> s.fb_cnt < fb_per)
    else $error("feedback counter beyond multiply period");
  a_serdes_mult_lim: assert property (
    locked |-> $past(!s.serdes || s.mult <= 6'(SERDES_MAX_MULT)))
    else $error("serializer mode locked with multiply above limit");
  a_lock_after_settle: assert property (
    $rose(locked) |-> $past(s.st == ST_ACQ && s.settle == 12'(SETTLE_CYCLES - 1)))
    else $error("lock rose without settling");
  a_settle_to_lock: assert property (
    seq_settled ##0 (run && cfg_ok && !ref_rise && !watch_to) |=> locked)
    else $error("settled but lock did not rise");
  a_lock_event_irq: assert property (
    $rose(locked) |-> s.irq_stat[IRQ_GAIN] ##1 !$fell(locked) || !run)
    else $error("lock gain not flagged");
  a_ext_route_glob: assert property (
    s.ext_sel == 2'd2 |=> ext_clk_pin == $past(global_clk))
    else $error("external pin does not follow global output");

endmodule // fpcs_top
`default_nettype wire

// ---- bench/fpcs_ref_model.sv ----
// Purpose: reference clock source for the synthesizer bench
// Assumes: period of 8*mult hclk cycles gives an aligned loop
// Notes:   a stopped source holds its line low
`timescale 1ns/1ps
`default_nettype none
module fpcs_ref_model
  import fpcs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [5:0] mult,
  output logic ref_clk
);
  int cnt;
  // ****************************************
  // square wave, half high half low
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      ref_clk <= 1'b0;
    end else if (!run) begin
      // a stopped source parks low and restarts at the period start
      cnt <= 0;
      ref_clk <= 1'b0;
    end else begin
      cnt <= (cnt >= 8 * mult - 1) ? 0 : cnt + 1;
      ref_clk <= (cnt < 4 * mult);
    end
  end
endmodule // fpcs_ref_model
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: self-checking bench for the clock synthesizer
// Assumes: hready looped back from hreadyout
// Notes:   reads are checked by a monitor through a queue
`timescale 1ns/1ps
`default_nettype none
module testbench
  import fpcs_pkg::*;
;
  localparam int ST = 20;
  typedef struct packed {logic [31:0] v; logic [31:0] m;} fpcs_exp_t;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ena = 1, ares = 1, run = 0, rdp = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [5:0] rm = 6'h08;
  logic [3:0] acc;
  wire [31:0] hrdata;
  wire hready, hresp, r0, r1, gc, ec, lk, irq, refc;
  int mismatches = 0, check_count = 0, hi, per, o, n, d;
  fpcs_exp_t q[$];
  fpcs_exp_t ce;
  int tb [6][5] = '{'{2, 100, 0, 1, 0}, '{11, 100, 0, 1, 0}, '{31, 30, 1, 1, 0},
                    '{30, 30, 1, 1, 1}, '{8, 100, 1, 2, 0}, '{32, 30, 0, 1, 1}};
  // clock
  always #12.5 hclk = ~hclk;
  fpcs_top #(.SETTLE_CYCLES(ST)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .ref_clk_in(refc), .pll_enable(ena), .pll_areset(ares), .regional_clk_0(r0),
    .regional_clk_1(r1), .global_clk(gc), .ext_clk_pin(ec), .locked(lk), .irq(irq));
  fpcs_ref_model REF (.hclk(hclk), .hresetn(hresetn), .run(run), .mult(rm), .ref_clk(refc));
  // ****************************************
  // compare and finish
  // ****************************************
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // read monitor, oldest note first
  always @(posedge hclk) begin
    if (rdp && hready === 1'b1 && q.size() > 0) begin
      ce = q.pop_front();
      check(hrdata & ce.m, ce.v);
      check(32'(hresp), 32'h0);
    end
    rdp <= hsel && htrans[1] && !hwrite && hready;
  end
  // ****************************************
  // bus and measurement tasks
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dt);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= dt;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    xfer(1'b1, a, dt);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    q.push_back('{e, m});
    xfer(1'b0, a, 32'h00000000);
  endtask
  task automatic waitlk(output int c);
    c = 0;
    while (lk !== 1'b1 && c < 3000) begin
      @(posedge hclk);
      c++;
    end
  endtask
  task automatic relock(output int c);
    ares <= 1'b1;
    repeat (2) @(posedge hclk);
    check(32'(lk), 32'h0);
    ares <= 1'b0;
    waitlk(c);
  endtask
  function automatic logic pick(int s);
    case (s)
      0: return r0;
      1: return r1;
      2: return gc;
      default: return ec;
    endcase
  endfunction
  task automatic meas(input int s, output int h, output int p);
    int c;
    logic lo;
    c = 0;
    lo = 0;
    while (pick(s) !== 1'b0 && c < 300) begin @(posedge hclk); c++; end
    while (pick(s) !== 1'b1 && c < 600) begin @(posedge hclk); c++; end
    h = 1;
    p = 0;
    while (!(lo && pick(s) === 1'b1) && p < 600) begin
      @(posedge hclk);
      p++;
      if (pick(s) !== 1'b1) lo = 1;
      else if (!lo) h++;
    end
  endtask
  task automatic offs(output int c);
    logic p0, p1;
    int k;
    p0 = r0;
    p1 = r1;
    c = -1;
    for (k = 0; k < 400; k++) begin
      @(posedge hclk);
      if (!p0 && r0 === 1'b1) c = 0;
      else if (c >= 0) c++;
      if (c >= 0 && !p1 && r1 === 1'b1) break;
      p0 = r0;
      p1 = r1;
    end
  endtask
  // watchdog
  initial begin
    #(25 * 60000);
    mismatches++;
    conclude();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(75));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(CTRL_OFS, 32'h0);
    rd(MULT_OFS, {26'h0, MULT_RST});
    rd(DIV_R0_OFS, {26'h0, DIV_RST});
    rd(DIV_R1_OFS, {26'h0, DIV_RST});
    rd(GOD_OFS, {26'h0, DIV_RST});
    rd(REF_MHZ_OFS, {22'h0, REF_MHZ_RST});
    rd(IRQ_MASK_OFS, 32'h0);
    rd(8'hFC, 32'h0);
    wr(STATUS_OFS, 32'hFFFFFFFF);
    rd(STATUS_OFS, 32'h0, 32'h1);
    done("reset values");
    d = $urandom_range(3, 1);
    wr(GOD_OFS, d);
    wr(DIV_R0_OFS, 32'h2);
    wr(DIV_R1_OFS, 32'h2);
    wr(SHIFT_OFS, 32'h00000300);
    wr(CTRL_OFS, 32'h8);
    wr(IRQ_MASK_OFS, 32'h1);
    run <= 1'b1;
    relock(n);
    check(32'(n > ST && n < 3000), 32'h1);
    check(32'(lk), 32'h1);
    rd(STATUS_OFS, 32'h3, 32'h7);
    rd(IRQ_STAT_OFS, 32'h1, 32'h1);
    check(32'(irq), 32'h1);
    meas(2, hi, per);
    check(per, 8 * d);
    check(hi, 4 * d);
    meas(3, hi, per);
    check(per, 8 * d);
    offs(o);
    check(o, 3);
    wr(IRQ_STAT_OFS, 32'h7);
    @(posedge hclk);
    check(32'(irq), 32'h0);
    done("lock and outputs");
    wr(CTRL_OFS, 32'hA);
    relock(n);
    offs(o);
    check(o, 0);
    done("common shift");
    wr(IRQ_STAT_OFS, 32'h7);
    wr(IRQ_MASK_OFS, 32'h2);
    ena <= 1'b0;
    repeat (2) @(posedge hclk);
    acc = 4'h0;
    repeat (40) begin
      @(posedge hclk);
      acc = acc | {r0, r1, gc, lk};
    end
    check(32'(acc), 32'h0);
    check(32'(irq), 32'h1);
    rd(IRQ_STAT_OFS, 32'h2, 32'h2);
    ena <= 1'b1;
    waitlk(n);
    check(32'(n > ST && n < 3000), 32'h1);
    done("enable");
    wr(IRQ_STAT_OFS, 32'h7);
    wr(IRQ_MASK_OFS, 32'h4);
    run <= 1'b0;
    n = 0;
    while (lk !== 1'b0 && n < 200) begin @(posedge hclk); n++; end
    check(32'(lk), 32'h0);
    rd(IRQ_STAT_OFS, 32'h6, 32'h6);
    check(32'(irq), 32'h1);
    run <= 1'b1;
    relock(n);
    check(32'(lk), 32'h1);
    done("reference stop");
    wr(IRQ_MASK_OFS, 32'h0);
    for (int i = 0; i < 6; i++) begin
      rm <= 6'(tb[i][0]);
      wr(MULT_OFS, tb[i][0]);
      wr(REF_MHZ_OFS, tb[i][1]);
      wr(CTRL_OFS, tb[i][2]);
      wr(DIV_R0_OFS, tb[i][3]);
      relock(n);
      rd(STATUS_OFS, 32'(tb[i][4] * 2), 32'h2);
      check(32'(lk), 32'(tb[i][4]));
    end
    done("configuration limits");
    conclude();
  end
endmodule // testbench
`default_nettype wire
